// *** verilog/fcoe_pkg.sv ***
/*
 * Shared constants of the flash command object and error-correction
 * capture front end: register byte offsets, field positions, reset
 * values, command codes and state encodings.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package fcoe_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [5:0] OFF_CLKDIV = 6'h00;
	localparam logic [5:0] OFF_CMD_IDX = 6'h04;
	localparam logic [5:0] OFF_ECC_IDX = 6'h08;
	localparam logic [5:0] OFF_STATUS = 6'h0c;
	localparam logic [5:0] OFF_ECC_STAT = 6'h10;
	localparam logic [5:0] OFF_CMD_OBJ = 6'h14;
	localparam logic [5:0] OFF_ECC_RES = 6'h18;
	localparam logic [5:0] OFF_OPTION = 6'h1c;
	localparam logic [5:0] OFF_RSV_A = 6'h20;
	localparam logic [5:0] OFF_RSV_B = 6'h24;
	localparam logic [5:0] OFF_RSV_C = 6'h28;
	localparam logic [5:0] OFF_RSV_D = 6'h2c;
	localparam logic [5:0] OFF_RSV_E = 6'h30;

	// Field positions
	localparam int DIV_LD_BIT = 7;
	localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
	localparam int STAT_ACCESS_ERROR_FLAG_BIT = 5;
	localparam int STAT_PROTECTION_VIOLATION_FLAG_BIT = 4;
	localparam int ECCS_SGL_BIT = 0;
	localparam int ECCS_DBL_BIT = 1;

	// Array geometry
	localparam int CMD_WORDS = 6;
	localparam logic [2:0] IDX_LAST = 3'h5;

	// Reset values, fault value and option address
	localparam logic [6:0] DIV_RST = 7'h00;
	localparam logic [7:0] OPT_RST = 8'h00;
	localparam logic [7:0] OPT_DBL_FAULT = 8'hff;
	localparam logic [22:0] NV_OPTION_ADDR = 23'h7fff0e;

	// Program and erase command codes
	localparam logic [7:0] CMD_PROG_P = 8'h06;
	localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
	localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
	localparam logic [7:0] CMD_ERASE_BLK = 8'h09;
	localparam logic [7:0] CMD_ERASE_PSEC = 8'h0a;
	localparam logic [7:0] CMD_PROG_D = 8'h11;
	localparam logic [7:0] CMD_ERASE_DSEC = 8'h12;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_BUSY = 2'b01
	} fcoe_cmd_state_e;

	typedef enum logic [1:0] {
		OPT_LOAD = 2'b00,
		OPT_DONE = 2'b01
	} fcoe_opt_state_e;

endpackage : fcoe_pkg

// *** verilog/fcoe_opt_loader.sv ***
/*
 * Option byte loader: fetches the nonvolatile option byte once after
 * reset and holds it read-only.
 * Assumes the flash read port answers the request with nv_valid_i.
 */
`timescale 1ns/1ns
module fcoe_opt_loader
	import fcoe_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Flash read port
	input wire logic nv_valid_i,
	input wire logic [7:0] nv_byte_i,
	input wire logic nv_double_fault_i,
	output logic nv_read_req_o,
	// Result
	output logic [7:0] option_byte_o,
	output logic load_done_o
);

	fcoe_opt_state_e state;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			state <= OPT_LOAD;
		else if (state == OPT_LOAD && nv_valid_i)
			state <= OPT_DONE;
		else
			state <= state;
	end

	// Request held from reset until the byte arrives
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			nv_read_req_o <= 1'b1;
		else if (nv_valid_i)
			nv_read_req_o <= 1'b0;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			load_done_o <= 1'b0;
		else if (state == OPT_LOAD && nv_valid_i)
			load_done_o <= 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			option_byte_o <= OPT_RST;
		else if (state == OPT_LOAD && nv_valid_i)
		begin
			if (nv_double_fault_i)
				option_byte_o <= OPT_DBL_FAULT;
			else
				option_byte_o <= nv_byte_i;
		end
	end

endmodule : fcoe_opt_loader

// *** verilog/fcoe_regs.sv ***
/*
 * Register front end of the flash controller: command object array,
 * launch handshake, error-correction fault capture, option byte,
 * reserved test registers and the divider write check.
 * Assumes an Avalon-MM master, a flash engine that answers each start
 * with exec_done_i, and fault pulses from the array read path.
 */
`timescale 1ns/1ns
// Function
// - six 16-bit words, byte writable, indexed
// - writing one to flag launches command
// - parameters locked while command runs
// - results valid once flag returns
// - indices six, seven ignore writes, read zero
// - word layout code, address, four data
// - reserved test registers read zero
// - fault result captured, word by index
// - no new capture until flag cleared
// - double fault wins over single
// - index zero parity, zero, high address
// - data flash parity top bits zero
// - program flash address, raw data phrase
// - data flash address, raw data word
// - result indices six, seven read zero
// - result readable, writes ignored
// - option byte loaded once after reset
// - double fault sets all option bits
// - option byte read only
// - divider write sets loaded flag
// - unloaded divider refuses program, erase
// - busy command ignores object writes
module fcoe_regs
	import fcoe_pkg::*;
#(
	parameter int AV_ADDR_W = 6
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [AV_ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Flash command engine
	output logic exec_start_o,
	output logic [7:0] exec_code_o,
	output logic [22:0] exec_addr_o,
	output logic [63:0] exec_data_o,
	output logic [6:0] divider_value_o,
	input wire logic exec_done_i,
	input wire logic exec_result_valid_i,
	input wire logic [95:0] exec_result_i,
	input wire logic exec_access_error_i,
	input wire logic exec_prot_viol_i,
	// Fault capture from array reads
	input wire logic ecc_single_i,
	input wire logic ecc_double_i,
	input wire logic ecc_pflash_i,
	input wire logic [7:0] ecc_parity_i,
	input wire logic [22:0] ecc_addr_i,
	input wire logic [63:0] ecc_data_i,
	// Option byte fetch
	input wire logic nv_valid_i,
	input wire logic [7:0] nv_byte_i,
	input wire logic nv_double_fault_i,
	output logic nv_read_req_o,
	output logic [22:0] nv_addr_o,
	output logic [7:0] option_byte_o
);

	initial
	begin
		if (AV_ADDR_W < 6)
			$error("AV_ADDR_W must be at least 6");
	end

	function automatic logic is_prog_erase(input logic [7:0] code);
		case (code)
			CMD_PROG_P, CMD_PROG_ONCE, CMD_ERASE_ALL, CMD_ERASE_BLK,
			CMD_ERASE_PSEC, CMD_PROG_D, CMD_ERASE_DSEC: is_prog_erase = 1'b1;
			default: is_prog_erase = 1'b0;
		endcase
	endfunction : is_prog_erase

	fcoe_cmd_state_e state;
	logic [15:0] cmd_obj [CMD_WORDS];
	logic [2:0] cmd_idx;
	logic [2:0] ecc_idx;
	logic command_complete_flag;
	logic access_error_flag;
	logic protection_violation_flag;
	logic div_loaded;
	logic ecc_sgl_flag;
	logic ecc_dbl_flag;
	logic ecc_was_double;
	logic [7:0] ecc_parity;
	logic [22:0] ecc_addr;
	logic [15:0] ecc_data [4];
	logic load_done;
	logic [31:0] next_readdata;
	logic [5:0] reg_off;
	logic in_range;
	logic rd_prep;
	logic wr_go;
	logic launch_req;
	logic launch_ok;
	logic launch_refused;
	logic ecc_event;
	logic ecc_free;

	assign reg_off = address_i[5:0];
	assign in_range = (address_i >> 6) == '0;
	// Answer one edge after the request, commit at the following one
	assign rd_prep = read_i && waitrequest_o;
	assign wr_go = write_i && !waitrequest_o;
	assign launch_req = wr_go && in_range && reg_off == OFF_STATUS && byteenable_i[0]
		&& writedata_i[STAT_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag && state == CMD_IDLE;
	assign launch_refused = launch_req && is_prog_erase(cmd_obj[0][15:8]) && !div_loaded;
	assign launch_ok = launch_req && !launch_refused;
	assign ecc_event = ecc_single_i || ecc_double_i;
	assign ecc_free = !ecc_sgl_flag && !ecc_dbl_flag;

	assign exec_code_o = cmd_obj[0][15:8];
	assign exec_addr_o = {cmd_obj[0][6:0], cmd_obj[1]};
	assign exec_data_o = {cmd_obj[2], cmd_obj[3], cmd_obj[4], cmd_obj[5]};
	assign nv_addr_o = NV_OPTION_ADDR;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			waitrequest_o <= 1'b1;
		else
			waitrequest_o <= !((read_i || write_i) && waitrequest_o);
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			cmd_idx <= 3'h0;
			ecc_idx <= 3'h0;
		end
		else if (wr_go && in_range && byteenable_i[0])
		begin
			if (reg_off == OFF_CMD_IDX)
				cmd_idx <= writedata_i[2:0];
			if (reg_off == OFF_ECC_IDX)
				ecc_idx <= writedata_i[2:0];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			divider_value_o <= DIV_RST;
			div_loaded <= 1'b0;
		end
		else if (wr_go && in_range && reg_off == OFF_CLKDIV && byteenable_i[0])
		begin
			divider_value_o <= writedata_i[6:0];
			div_loaded <= 1'b1;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			for (int i = 0; i < CMD_WORDS; i++)
				cmd_obj[i] <= 16'h0000;
		end
		else if (state == CMD_BUSY && exec_done_i && exec_result_valid_i)
		begin
			for (int i = 0; i < CMD_WORDS; i++)
				cmd_obj[i] <= exec_result_i[95-16*i -: 16];
		end
		else if (wr_go && in_range && reg_off == OFF_CMD_OBJ && command_complete_flag
			&& state == CMD_IDLE && cmd_idx <= IDX_LAST)
		begin
			if (byteenable_i[0])
				cmd_obj[cmd_idx][7:0] <= writedata_i[7:0];
			if (byteenable_i[1])
				cmd_obj[cmd_idx][15:8] <= writedata_i[15:8];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			state <= CMD_IDLE;
			command_complete_flag <= 1'b0;
			exec_start_o <= 1'b0;
		end
		else
		begin
			exec_start_o <= launch_ok;
			case (state)
				CMD_IDLE:
				begin
					if (launch_ok)
					begin
						state <= CMD_BUSY;
						command_complete_flag <= 1'b0;
					end
					else if (load_done)
						command_complete_flag <= 1'b1;
				end
				CMD_BUSY:
				begin
					if (exec_done_i)
					begin
						state <= CMD_IDLE;
						command_complete_flag <= 1'b1;
					end
				end
				default:
				begin
					state <= CMD_IDLE;
					command_complete_flag <= 1'b0;
				end
			endcase
		end
	end

	// Hardware set wins over a same-cycle clear
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			access_error_flag <= 1'b0;
			protection_violation_flag <= 1'b0;
		end
		else
		begin
			if (launch_refused || (exec_done_i && exec_access_error_i))
				access_error_flag <= 1'b1;
			else if (wr_go && in_range && reg_off == OFF_STATUS && byteenable_i[0]
				&& writedata_i[STAT_ACCESS_ERROR_FLAG_BIT])
				access_error_flag <= 1'b0;
			if (exec_done_i && exec_prot_viol_i)
				protection_violation_flag <= 1'b1;
			else if (wr_go && in_range && reg_off == OFF_STATUS && byteenable_i[0]
				&& writedata_i[STAT_PROTECTION_VIOLATION_FLAG_BIT])
				protection_violation_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			ecc_sgl_flag <= 1'b0;
			ecc_dbl_flag <= 1'b0;
		end
		else
		begin
			if (ecc_single_i)
				ecc_sgl_flag <= 1'b1;
			else if (wr_go && in_range && reg_off == OFF_ECC_STAT && byteenable_i[0]
				&& writedata_i[ECCS_SGL_BIT])
				ecc_sgl_flag <= 1'b0;
			if (ecc_double_i)
				ecc_dbl_flag <= 1'b1;
			else if (wr_go && in_range && reg_off == OFF_ECC_STAT && byteenable_i[0]
				&& writedata_i[ECCS_DBL_BIT])
				ecc_dbl_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			ecc_was_double <= 1'b0;
			ecc_parity <= 8'h00;
			ecc_addr <= 23'h000000;
			for (int i = 0; i < 4; i++)
				ecc_data[i] <= 16'h0000;
		end
		else if (ecc_event && ecc_free)
		begin
			ecc_was_double <= ecc_double_i;
			ecc_addr <= ecc_addr_i;
			if (ecc_pflash_i)
			begin
				ecc_parity <= ecc_parity_i;
				for (int i = 0; i < 4; i++)
					ecc_data[i] <= ecc_data_i[63-16*i -: 16];
			end
			else
			begin
				ecc_parity <= {2'b00, ecc_parity_i[5:0]};
				ecc_data[0] <= ecc_data_i[15:0];
				for (int i = 1; i < 4; i++)
					ecc_data[i] <= 16'h0000;
			end
		end
	end

	always_comb
	begin
		next_readdata = 32'h00000000;
		if (in_range)
		begin
			case (reg_off)
				OFF_CLKDIV: next_readdata[7:0] = {div_loaded, divider_value_o};
				OFF_CMD_IDX: next_readdata[2:0] = cmd_idx;
				OFF_ECC_IDX: next_readdata[2:0] = ecc_idx;
				OFF_STATUS:
				begin
					next_readdata[STAT_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
					next_readdata[STAT_ACCESS_ERROR_FLAG_BIT] = access_error_flag;
					next_readdata[STAT_PROTECTION_VIOLATION_FLAG_BIT] = protection_violation_flag;
				end
				OFF_ECC_STAT:
				begin
					next_readdata[ECCS_SGL_BIT] = ecc_sgl_flag;
					next_readdata[ECCS_DBL_BIT] = ecc_dbl_flag;
				end
				OFF_CMD_OBJ:
				begin
					if (cmd_idx <= IDX_LAST)
						next_readdata[15:0] = cmd_obj[cmd_idx];
				end
				OFF_ECC_RES:
				begin
					case (ecc_idx)
						3'h0: next_readdata[15:0] = {ecc_parity, 1'b0, ecc_addr[22:16]};
						3'h1: next_readdata[15:0] = ecc_addr[15:0];
						3'h2: next_readdata[15:0] = ecc_data[0];
						3'h3: next_readdata[15:0] = ecc_data[1];
						3'h4: next_readdata[15:0] = ecc_data[2];
						3'h5: next_readdata[15:0] = ecc_data[3];
						default: next_readdata[15:0] = 16'h0000;
					endcase
				end
				OFF_OPTION: next_readdata[7:0] = option_byte_o;
				default: next_readdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			readdata_o <= 32'h00000000;
		else if (rd_prep)
			readdata_o <= next_readdata;
	end

	fcoe_opt_loader u_opt_loader (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.nv_valid_i(nv_valid_i),
		.nv_byte_i(nv_byte_i),
		.nv_double_fault_i(nv_double_fault_i),
		.nv_read_req_o(nv_read_req_o),
		.option_byte_o(option_byte_o),
		.load_done_o(load_done)
	);

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_launch;
		launch_ok;
	endsequence

	sequence s_started;
		!command_complete_flag && exec_start_o && state == CMD_BUSY;
	endsequence

	a_launch_clears_flag: assert property (s_launch |=> s_started)
		else $error("launch did not clear flag and start");
	a_object_locked: assert property (!command_complete_flag |=> $stable(cmd_obj[0]) || $past(exec_done_i))
		else $error("command object changed while busy");
	a_results_with_flag: assert property (
		state == CMD_BUSY && exec_done_i && exec_result_valid_i
		|=> command_complete_flag && cmd_obj[0] == $past(exec_result_i[95:80]))
		else $error("results not paired with flag");
	a_unimpl_read_zero: assert property (
		rd_prep && in_range && reg_off == OFF_CMD_OBJ && cmd_idx > IDX_LAST
		|=> readdata_o == 32'h00000000)
		else $error("unimplemented command word read nonzero");
	a_reserved_zero: assert property (
		rd_prep && in_range && reg_off >= OFF_RSV_A |=> readdata_o == 32'h00000000)
		else $error("reserved register read nonzero");
	a_capture_held: assert property (!ecc_free |=> $stable(ecc_addr) && $stable(ecc_parity))
		else $error("fault details overwritten");
	a_double_first: assert property (
		ecc_free && ecc_single_i && ecc_double_i |=> ecc_was_double
		&& ecc_addr == $past(ecc_addr_i))
		else $error("single fault recorded over double");
	a_option_ones: assert property (
		nv_read_req_o && nv_valid_i && nv_double_fault_i |=> option_byte_o == 8'hff)
		else $error("option byte not all ones after double fault");
	a_divider_loaded: assert property (
		wr_go && in_range && reg_off == OFF_CLKDIV && byteenable_i[0]
		|=> div_loaded ##1 div_loaded)
		else $error("divider write did not set loaded flag");
	a_refuse_unloaded: assert property (launch_refused |=> access_error_flag && command_complete_flag && !exec_start_o)
		else $error("program or erase ran without divider");
	a_bus_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("bus answer late");

endmodule : fcoe_regs

// *** sim/tb.sv ***
/*
 * Self-checking bench of the flash register front end.
 * Assumes fcoe_pkg and fcoe_regs are compiled first; the bench acts as
 * bus master, command engine, array fault source and option fetch.
 */
`timescale 1ns/1ns
module tb
	import fcoe_pkg::*;
;
	logic mclk_i, rst_n_i, read_i, write_i, waitrequest_o, exec_start_o;
	logic [5:0] address_i;
	logic [3:0] byteenable_i;
	logic [31:0] writedata_i, readdata_o, rd;
	logic [7:0] exec_code_o, ecc_parity_i, nv_byte_i, option_byte_o;
	logic [22:0] exec_addr_o, ecc_addr_i, nv_addr_o;
	logic [63:0] exec_data_o, ecc_data_i;
	logic [6:0] divider_value_o;
	logic [95:0] exec_result_i;
	logic exec_done_i, exec_result_valid_i, exec_access_error_i, exec_prot_viol_i;
	logic ecc_single_i, ecc_double_i, ecc_pflash_i, nv_valid_i, nv_double_fault_i;
	logic nv_read_req_o;
	int failures, num_checks, cycles, starts;

	fcoe_regs #(.AV_ADDR_W(6)) fcoe_regs_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .exec_start_o(exec_start_o),
		.exec_code_o(exec_code_o), .exec_addr_o(exec_addr_o), .exec_data_o(exec_data_o),
		.divider_value_o(divider_value_o), .exec_done_i(exec_done_i),
		.exec_result_valid_i(exec_result_valid_i), .exec_result_i(exec_result_i),
		.exec_access_error_i(exec_access_error_i), .exec_prot_viol_i(exec_prot_viol_i),
		.ecc_single_i(ecc_single_i), .ecc_double_i(ecc_double_i),
		.ecc_pflash_i(ecc_pflash_i), .ecc_parity_i(ecc_parity_i), .ecc_addr_i(ecc_addr_i),
		.ecc_data_i(ecc_data_i), .nv_valid_i(nv_valid_i), .nv_byte_i(nv_byte_i),
		.nv_double_fault_i(nv_double_fault_i), .nv_read_req_o(nv_read_req_o),
		.nv_addr_o(nv_addr_o), .option_byte_o(option_byte_o));

	initial
	begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	// Hang guard, also counts launches seen by the engine side
	always @(posedge mclk_i)
	begin
		cycles++;
		if (exec_start_o === 1'b1)
			starts++;
		if (cycles == 5000)
		begin
			$display("unexpected at %0t: timeout %h %h", $time, cycles, 0);
			failures++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask : check

	// One Avalon access; request held until waitrequest sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int n;
		@(posedge mclk_i);
		address_i <= a;
		writedata_i <= d;
		byteenable_i <= be;
		read_i <= !wr;
		write_i <= wr;
		n = 0;
		do
		begin
			@(posedge mclk_i);
			n++;
		end
		while (waitrequest_o !== 1'b0 && n < 20);
		if (n >= 20)
			check(32'(n), 32'h1);
		rd = readdata_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		writedata_i <= ~d;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr

	task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		check(rd, exp);
	endtask : rdchk

	task automatic obj_rd(input logic [2:0] i, input logic [15:0] exp);
		wr(OFF_CMD_IDX, 32'(i));
		rdchk(OFF_CMD_OBJ, 32'(exp));
	endtask : obj_rd

	task automatic ecc_rd(input logic [2:0] i, input logic [15:0] exp);
		wr(OFF_ECC_IDX, 32'(i));
		rdchk(OFF_ECC_RES, 32'(exp));
	endtask : ecc_rd

	task automatic do_reset(input logic [7:0] nv, input logic dbl);
		@(posedge mclk_i);
		rst_n_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		check(32'(nv_read_req_o), 32'h1);
		check(32'(nv_addr_o), 32'(NV_OPTION_ADDR));
		nv_byte_i <= nv;
		nv_double_fault_i <= dbl;
		nv_valid_i <= 1'b1;
		@(posedge mclk_i);
		nv_valid_i <= 1'b0;
		nv_byte_i <= ~nv;
		nv_double_fault_i <= ~dbl;
		repeat (3) @(posedge mclk_i);
		check(32'(nv_read_req_o), 32'h0);
	endtask : do_reset

	task automatic fault(input logic s, input logic d, input logic pf, input logic [7:0] par,
		input logic [22:0] a, input logic [63:0] dat);
		@(posedge mclk_i);
		{ecc_single_i, ecc_double_i, ecc_pflash_i} <= {s, d, pf};
		{ecc_parity_i, ecc_addr_i, ecc_data_i} <= {par, a, dat};
		@(posedge mclk_i);
		{ecc_single_i, ecc_double_i} <= 2'b00;
		{ecc_parity_i, ecc_addr_i, ecc_data_i} <= ~{par, a, dat};
	endtask : fault

	task automatic t_option_reserved;
		logic [5:0] offs [6];
		offs = '{OFF_RSV_A, OFF_RSV_B, OFF_RSV_C, OFF_RSV_D, OFF_RSV_E, 6'h34};
		rdchk(OFF_OPTION, 32'h5a);
		wr(OFF_OPTION, 32'hff);
		rdchk(OFF_OPTION, 32'h5a);
		check(32'(option_byte_o), 32'h5a);
		rdchk(OFF_CLKDIV, 32'h0);
		foreach (offs[i])
		begin
			wr(offs[i], 32'hffffffff);
			rdchk(offs[i], 32'h0);
		end
	endtask : t_option_reserved

	// Every program and erase code refused while divider unwritten
	task automatic t_refuse;
		logic [7:0] codes [7];
		codes = '{CMD_PROG_P, CMD_PROG_ONCE, CMD_ERASE_ALL, CMD_ERASE_BLK, CMD_ERASE_PSEC,
			CMD_PROG_D, CMD_ERASE_DSEC};
		foreach (codes[i])
		begin
			wr(OFF_CMD_IDX, 32'h0);
			wr(OFF_CMD_OBJ, {16'h0, codes[i], 8'h00});
			wr(OFF_STATUS, 32'h80);
			rdchk(OFF_STATUS, 32'ha0);
			wr(OFF_STATUS, 32'h20);
			rdchk(OFF_STATUS, 32'h80);
		end
		check(32'(starts), 32'h0);
	endtask : t_refuse

	task automatic t_launch;
		wr(OFF_CLKDIV, 32'h13);
		rdchk(OFF_CLKDIV, 32'h93);
		check(32'(divider_value_o), 32'h13);
		wr(OFF_CMD_IDX, 32'h0);
		bus(1'b1, OFF_CMD_OBJ, 32'h5512, 4'h1);
		bus(1'b1, OFF_CMD_OBJ, 32'h0677, 4'h2);
		obj_rd(3'h0, 16'h0612);
		wr(OFF_CMD_OBJ, 32'h0612);
		for (int i = 1; i < 8; i++)
		begin
			wr(OFF_CMD_IDX, 32'(i));
			wr(OFF_CMD_OBJ, (i == 1) ? 32'h3456 : 32'hd000 + 32'(i));
		end
		obj_rd(3'h6, 16'h0);
		obj_rd(3'h7, 16'h0);
		obj_rd(3'h5, 16'hd005);
		wr(OFF_STATUS, 32'h80);
		repeat (2) @(posedge mclk_i);
		check(32'(starts), 32'h1);
		check(32'(exec_code_o), 32'h06);
		check(32'(exec_addr_o), 32'h123456);
		check(exec_data_o[63:32], 32'hd002d003);
		check(exec_data_o[31:0], 32'hd004d005);
		rdchk(OFF_STATUS, 32'h0);
		wr(OFF_CMD_IDX, 32'h1);
		wr(OFF_CMD_OBJ, 32'hbeef);
		wr(OFF_STATUS, 32'h80);
		repeat (2) @(posedge mclk_i);
		check(32'(starts), 32'h1);
		check(32'(exec_addr_o), 32'h123456);
		@(posedge mclk_i);
		{exec_done_i, exec_result_valid_i, exec_prot_viol_i} <= 3'b111;
		exec_result_i <= 96'h1111_2222_3333_4444_5555_6666;
		@(posedge mclk_i);
		{exec_done_i, exec_result_valid_i, exec_prot_viol_i} <= 3'b000;
		exec_result_i <= ~96'h1111_2222_3333_4444_5555_6666;
		rdchk(OFF_STATUS, 32'h90);
		for (int i = 0; i < 6; i++)
			obj_rd(3'(i), 16'h1111 * 16'(i + 1));
		wr(OFF_STATUS, 32'h10);
		rdchk(OFF_STATUS, 32'h80);
	endtask : t_launch

	task automatic t_ecc;
		fault(1'b1, 1'b1, 1'b1, 8'hc5, 23'h5a1234, 64'h0123_4567_89ab_cdef);
		bus(1'b0, OFF_ECC_STAT, 32'h0, 4'hf);
		check(32'(rd[ECCS_DBL_BIT]), 32'h1);
		ecc_rd(3'h0, 16'hc55a);
		ecc_rd(3'h1, 16'h1234);
		ecc_rd(3'h2, 16'h0123);
		ecc_rd(3'h3, 16'h4567);
		ecc_rd(3'h4, 16'h89ab);
		ecc_rd(3'h5, 16'hcdef);
		ecc_rd(3'h6, 16'h0);
		ecc_rd(3'h7, 16'h0);
		fault(1'b1, 1'b0, 1'b1, 8'h11, 23'h000777, 64'h0);
		ecc_rd(3'h1, 16'h1234);
		wr(OFF_ECC_RES, 32'hffff);
		ecc_rd(3'h1, 16'h1234);
		wr(OFF_ECC_STAT, 32'h3);
		rdchk(OFF_ECC_STAT, 32'h0);
		fault(1'b1, 1'b0, 1'b0, 8'hff, 23'h010203, 64'h5555_6666_7777_abcd);
		ecc_rd(3'h0, 16'h3f01);
		ecc_rd(3'h1, 16'h0203);
		ecc_rd(3'h2, 16'habcd);
		ecc_rd(3'h3, 16'h0);
		wr(OFF_ECC_STAT, 32'h3);
	endtask : t_ecc

	task automatic t_reset_dbl;
		do_reset(8'h3c, 1'b1);
		rdchk(OFF_OPTION, 32'hff);
		rdchk(OFF_CLKDIV, 32'h0);
	endtask : t_reset_dbl

	initial
	begin
		{rst_n_i, read_i, write_i, address_i, byteenable_i, writedata_i} = '0;
		{exec_done_i, exec_result_valid_i, exec_access_error_i, exec_prot_viol_i} = '0;
		exec_result_i = '0;
		{ecc_single_i, ecc_double_i, ecc_pflash_i, ecc_parity_i, ecc_addr_i} = '0;
		{ecc_data_i, nv_valid_i, nv_byte_i, nv_double_fault_i} = '0;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		starts = 0;
		do_reset(8'h5a, 1'b0);
		t_option_reserved();
		t_refuse();
		t_launch();
		t_ecc();
		t_reset_dbl();
		end_of_test();
	end
endmodule : tb
